/* File: clk_gen_pkg.sv */
// constants and types of the system clock source controller
// assumes a byte-wide processor register port and oscillator ticks on mclk
package clk_gen_pkg;
    // ----------------------------------------------------------------
    // register map
    // ----------------------------------------------------------------
    localparam logic [15:0] SUB_OSC_MODE_ADDR  = 16'hfff0;
    localparam logic [15:0] SUBCLK_CTRL_ADDR   = 16'hfff2;
    localparam logic [15:0] PROC_CLK_CTRL_ADDR = 16'hfffb;
    localparam logic [7:0]  SUB_OSC_MODE_RST   = 8'h00;
    localparam logic [7:0]  SUBCLK_CTRL_RST    = 8'h00;
    localparam logic [7:0]  PROC_CLK_CTRL_RST  = 8'h02;
    localparam logic [7:0]  SUB_OSC_MODE_WMASK = 8'h03;
    localparam logic [7:0]  SUBCLK_CTRL_WMASK  = 8'h10;
    localparam logic [7:0]  PROC_CLK_CTRL_WMASK = 8'h82;
    localparam int SUB_OSC_HALT_BIT = 0;
    localparam int FB_RES_OFF_BIT   = 1;
    localparam int CLK_SRC_SEL_BIT  = 4;
    localparam int CPU_SRC_FLAG_BIT = 5;
    localparam int MAIN_DIV_SEL_BIT = 1;
    localparam int MAIN_OSC_HALT_BIT = 7;
    // ----------------------------------------------------------------
    // clock ratios and counts
    // ----------------------------------------------------------------
    localparam logic [1:0] MAIN_SLOW_DIV_LAST = 2'h3;
    localparam logic [1:0] SWITCH_TICKS_LAST  = 2'h1;
    localparam int STAB_EXP = 15;
    // ----------------------------------------------------------------
    // types
    // ----------------------------------------------------------------
    typedef struct packed {
        logic [15:0] addr;
        logic        rd;
        logic        wr;
        logic [7:0]  wdata;
        logic        bit_wr;
        logic [2:0]  bit_idx;
        logic        bit_val;
    } reg_req_t;
    typedef enum logic [2:0] {
        SRC_FAST = 3'b001,
        SRC_SLOW = 3'b010,
        SRC_SUB  = 3'b100
    } cpu_src_t;
    typedef enum logic [3:0] {
        PWR_STAB = 4'b0001,
        PWR_RUN  = 4'b0010,
        PWR_HALT = 4'b0100,
        PWR_STOP = 4'b1000
    } pwr_state_t;
endpackage

/* File: system_clock_source_control.sv */
// system clock source controller: registers, CPU clock pick, standby gating
// assumes oscillator ticks arrive as one-cycle pulses synchronous to mclk
module system_clock_source_control #(
    parameter int STAB_TICKS = 2 ** clk_gen_pkg::STAB_EXP
) (
    input  wire logic                  mclk,
    input  wire logic                  srst,
    input  wire clk_gen_pkg::reg_req_t req,
    output logic [7:0]                 rdata,
    input  wire logic                  main_osc_tick,
    input  wire logic                  sub_osc_tick,
    input  wire logic                  stop_req,
    input  wire logic                  halt_req,
    input  wire logic                  wake,
    output logic                       main_osc_en,
    output logic                       sub_osc_en,
    output logic                       feedback_resistor_off,
    output logic                       cpu_clk_en,
    output logic                       cpu_running,
    output logic                       cpu_clk_source_flag,
    output logic                       periph_clk_en,
    output logic                       watch_clk_en,
    output logic                       stop_mode,
    output logic                       halt_mode
);
    import clk_gen_pkg::*;

    // ----------------------------------------------------------------
    // register access
    // ----------------------------------------------------------------
    logic [7:0]  sub_osc_mode_reg_q;
    logic [7:0]  subclk_ctrl_reg_q;
    logic [7:0]  proc_clk_ctrl_reg_q;
    logic [7:0]  rdata_q;
    cpu_src_t    cur_src_q;
    pwr_state_t  pwr_q;
    pwr_state_t  pwr_d;

    // byte write replaces, bit write changes one bit; masks keep zeros
    function automatic logic [7:0] merge(
        input logic [7:0] old,
        input logic [7:0] wmask,
        input reg_req_t   r
    );
        logic [7:0] v;
        v = old;
        if (r.wr) begin
            v = r.wdata;
        end else if (r.bit_wr) begin
            v[r.bit_idx] = r.bit_val;
        end
        return v & wmask;
    endfunction

    wire         hit_mode  = req.addr == SUB_OSC_MODE_ADDR;
    wire         hit_sctl  = req.addr == SUBCLK_CTRL_ADDR;
    wire         hit_pctl  = req.addr == PROC_CLK_CTRL_ADDR;
    wire         wr_any    = req.wr | req.bit_wr;
    wire         on_sub    = cur_src_q == SRC_SUB;
    wire [7:0]   mode_new  = merge(sub_osc_mode_reg_q, SUB_OSC_MODE_WMASK, req);
    wire [7:0]   sctl_new  = merge(subclk_ctrl_reg_q, SUBCLK_CTRL_WMASK, req);
    wire [7:0]   pctl_mrg  = merge(proc_clk_ctrl_reg_q, PROC_CLK_CTRL_WMASK, req);
    // setting the main halt bit only counts once the sub clock is in use
    wire         halt_new  = pctl_mrg[MAIN_OSC_HALT_BIT] & on_sub;
    wire [7:0]   pctl_new  = {halt_new, pctl_mrg[6:0]};
    wire [7:0]   sctl_rd   = subclk_ctrl_reg_q | ({7'h00, on_sub} << CPU_SRC_FLAG_BIT);
    wire [7:0]   rd_mux    = hit_mode ? sub_osc_mode_reg_q :
                             hit_sctl ? sctl_rd :
                             hit_pctl ? proc_clk_ctrl_reg_q : 8'h00;

    always_ff @(posedge mclk) begin
        if (srst) begin
            sub_osc_mode_reg_q  <= SUB_OSC_MODE_RST;
            subclk_ctrl_reg_q   <= SUBCLK_CTRL_RST;
            proc_clk_ctrl_reg_q <= PROC_CLK_CTRL_RST;
            rdata_q             <= 8'h00;
        end else begin
            if (wr_any && hit_mode) begin
                sub_osc_mode_reg_q <= mode_new;
            end
            if (wr_any && hit_sctl) begin
                subclk_ctrl_reg_q <= sctl_new;
            end
            if (wr_any && hit_pctl) begin
                proc_clk_ctrl_reg_q <= pctl_new;
            end
            if (req.rd) begin
                rdata_q <= rd_mux;
            end
        end
    end

    assign rdata                 = rdata_q;
    assign feedback_resistor_off = sub_osc_mode_reg_q[FB_RES_OFF_BIT];
    assign sub_osc_en            = ~sub_osc_mode_reg_q[SUB_OSC_HALT_BIT];
    assign cpu_clk_source_flag   = on_sub;

    // ----------------------------------------------------------------
    // oscillator enables and clock dividers
    // ----------------------------------------------------------------
    logic        main_osc_en_q;
    logic [1:0]  main_div_q;
    logic        sub_div_q;
    logic [1:0]  sw_cnt_q;
    logic        cpu_clk_en_q;
    logic        periph_clk_en_q;
    logic        watch_clk_en_q;

    // deep standby and the halt bit both stop the main oscillator
    wire main_en_d = ~proc_clk_ctrl_reg_q[MAIN_OSC_HALT_BIT] & (pwr_q != PWR_STOP);
    wire main_t    = main_osc_tick & main_osc_en_q;
    wire slow_t    = main_t & (main_div_q == MAIN_SLOW_DIV_LAST);
    wire sub_t     = sub_osc_tick & sub_osc_en;
    wire sub_half_t = sub_t & sub_div_q;
    wire cpu_sub   = subclk_ctrl_reg_q[CLK_SRC_SEL_BIT];
    wire cpu_slow  = proc_clk_ctrl_reg_q[MAIN_DIV_SEL_BIT];
    // requested source from select bit and divider bit
    cpu_src_t req_src;
    assign req_src = cpu_sub ? SRC_SUB : (cpu_slow ? SRC_SLOW : SRC_FAST);
    logic src_t;
    always_comb begin
        case (cur_src_q)
            SRC_FAST: src_t = main_t;
            SRC_SLOW: src_t = slow_t;
            SRC_SUB:  src_t = sub_half_t;
            default:  src_t = 1'b0;
        endcase
    end
    wire sw_pend = req_src != cur_src_q;
    wire sw_done = sw_pend & src_t & (sw_cnt_q == SWITCH_TICKS_LAST);

    always_ff @(posedge mclk) begin
        if (srst) begin
            main_osc_en_q <= 1'b0;
            main_div_q    <= 2'h0;
            sub_div_q     <= 1'b0;
        end else begin
            main_osc_en_q <= main_en_d;
            main_div_q    <= main_t ? main_div_q + 2'h1 : main_div_q;
            sub_div_q     <= sub_t ? ~sub_div_q : sub_div_q;
        end
    end

    // the new source takes over only after two ticks of the old one
    always_ff @(posedge mclk) begin
        if (srst) begin
            cur_src_q <= SRC_SLOW;
            sw_cnt_q  <= 2'h0;
        end else if (!sw_pend) begin
            sw_cnt_q <= 2'h0;
        end else if (sw_done) begin
            cur_src_q <= req_src;
            sw_cnt_q  <= 2'h0;
        end else if (src_t) begin
            sw_cnt_q <= sw_cnt_q + 2'h1;
        end
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            cpu_clk_en_q    <= 1'b0;
            periph_clk_en_q <= 1'b0;
            watch_clk_en_q  <= 1'b0;
        end else begin
            cpu_clk_en_q    <= src_t & (pwr_q == PWR_RUN);
            periph_clk_en_q <= main_t;
            watch_clk_en_q  <= sub_t;
        end
    end

    assign main_osc_en   = main_osc_en_q;
    assign cpu_clk_en    = cpu_clk_en_q;
    assign periph_clk_en = periph_clk_en_q;
    assign watch_clk_en  = watch_clk_en_q;

    // ----------------------------------------------------------------
    // stabilization wait and standby modes
    // ----------------------------------------------------------------
    logic [15:0] stab_cnt_q;
    wire  stab_done = main_t && (stab_cnt_q == 16'(STAB_TICKS - 1));

    always_comb begin
        pwr_d = pwr_q;
        case (pwr_q)
            PWR_STAB: begin
                if (stab_done) begin
                    pwr_d = PWR_RUN;
                end
            end
            PWR_RUN: begin
                if (stop_req && !on_sub) begin
                    pwr_d = PWR_STOP;
                end else if (halt_req) begin
                    pwr_d = PWR_HALT;
                end
            end
            PWR_HALT: begin
                if (wake) begin
                    pwr_d = PWR_RUN;
                end
            end
            PWR_STOP: begin
                if (wake) begin
                    pwr_d = PWR_STAB;
                end
            end
            default: pwr_d = PWR_STAB;
        endcase
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            pwr_q      <= PWR_STAB;
            stab_cnt_q <= 16'h0000;
        end else begin
            pwr_q      <= pwr_d;
            stab_cnt_q <= (pwr_q != PWR_STAB) ? 16'h0000 :
                          main_t ? stab_cnt_q + 16'h0001 : stab_cnt_q;
        end
    end

    assign cpu_running = pwr_q == PWR_RUN;
    assign stop_mode   = pwr_q == PWR_STOP;
    assign halt_mode   = pwr_q == PWR_HALT;

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (srst);

    property p_reset_values;
        $fell(srst) |-> sub_osc_mode_reg_q == 8'h00 && subclk_ctrl_reg_q == 8'h00
            && proc_clk_ctrl_reg_q == 8'h02 && !main_osc_en_q;
    endproperty
    a_reset_values: assert property (p_reset_values)
        else $error("reset values wrong");

    property p_fb_write;
        req.wr && hit_mode |=> feedback_resistor_off == $past(req.wdata[1])
            && sub_osc_en == !$past(req.wdata[0]);
    endproperty
    a_fb_write: assert property (p_fb_write)
        else $error("mode write not applied");

    property p_flag_ro;
        (req.wr || req.bit_wr) && hit_sctl |=> subclk_ctrl_reg_q[5] == 1'b0;
    endproperty
    a_flag_ro: assert property (p_flag_ro)
        else $error("status bit stored");

    property p_halt_bit_ignore;
        req.wr && hit_pctl && req.wdata[7] && !on_sub |=> !proc_clk_ctrl_reg_q[7];
    endproperty
    a_halt_bit_ignore: assert property (p_halt_bit_ignore)
        else $error("main halt taken on main");

    property p_switch_delay;
        sw_pend && sw_cnt_q == 2'h0 && !src_t |=> cur_src_q == $past(cur_src_q);
    endproperty
    a_switch_delay: assert property (p_switch_delay)
        else $error("clock switch too early");

    property p_switch_bound;
        sw_pend && src_t && sw_cnt_q == 2'h1 |=> cur_src_q == $past(req_src)
            && cpu_clk_source_flag == $past(cpu_sub);
    endproperty
    a_switch_bound: assert property (p_switch_bound)
        else $error("switch not done");

    property p_no_stop_on_sub;
        pwr_q == PWR_RUN && stop_req && on_sub |=> pwr_q != PWR_STOP;
    endproperty
    a_no_stop_on_sub: assert property (p_no_stop_on_sub)
        else $error("deep standby on sub");

    property p_periph_gated;
        !main_osc_en_q |=> !periph_clk_en;
    endproperty
    a_periph_gated: assert property (p_periph_gated)
        else $error("peripheral clock while stopped");

    property p_stab_wait;
        pwr_q == PWR_STAB |=> !cpu_clk_en;
    endproperty
    a_stab_wait: assert property (p_stab_wait)
        else $error("cpu clocked before wait");

    property p_stop_main_off;
        pwr_q == PWR_STOP |=> !main_osc_en;
    endproperty
    a_stop_main_off: assert property (p_stop_main_off)
        else $error("main oscillator runs in deep standby");

    property p_halt_quiet;
        pwr_q == PWR_HALT |=> !cpu_clk_en;
    endproperty
    a_halt_quiet: assert property (p_halt_quiet)
        else $error("cpu clocked in light standby");

    property p_flag_steady;
        !sw_done |=> $stable(cpu_clk_source_flag);
    endproperty
    a_flag_steady: assert property (p_flag_steady)
        else $error("status flag moved without a switch");

    property p_watch_src;
        watch_clk_en |-> $past(sub_osc_tick && sub_osc_en);
    endproperty
    a_watch_src: assert property (p_watch_src)
        else $error("watch clock without sub tick");
endmodule

/* File: osc_model.sv */
// oscillator model: tick pulses on mclk while each oscillator is enabled
// assumes the enables come from the clock controller under test
module osc_model #(
    parameter int MAIN_DIV = 2,
    parameter int SUB_DIV  = 7
) (
    input  wire logic mclk,
    input  wire logic main_osc_en,
    input  wire logic sub_osc_en,
    output logic      main_osc_tick,
    output logic      sub_osc_tick
);
    timeunit 1ns;
    timeprecision 1ps;
    int mcnt = 0;
    int scnt = 0;
    initial main_osc_tick = 1'b0;
    initial sub_osc_tick = 1'b0;
    // a stopped oscillator gives no ticks at all
    always @(posedge mclk) begin
        mcnt <= main_osc_en ? (mcnt + 1) % MAIN_DIV : 0;
        scnt <= sub_osc_en ? (scnt + 1) % SUB_DIV : 0;
        main_osc_tick <= main_osc_en && mcnt == MAIN_DIV - 1;
        sub_osc_tick <= sub_osc_en && scnt == SUB_DIV - 1;
    end
endmodule

/* File: testbench.sv */
// self-checking bench for the system clock source controller
// assumes osc_model supplies the oscillator ticks
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    import clk_gen_pkg::*;
    logic       mclk = 1'b0;
    logic       srst = 1'b1;
    reg_req_t   req = '0;
    logic       stop_req = 1'b0;
    logic       halt_req = 1'b0;
    logic       wake = 1'b0;
    logic [7:0] rdata, d;
    logic       main_osc_tick, sub_osc_tick, main_osc_en, sub_osc_en, feedback_resistor_off;
    logic       cpu_clk_en, cpu_running, cpu_clk_source_flag, periph_clk_en, watch_clk_en;
    logic       stop_mode, halt_mode;
    logic       rd_d = 1'b0;
    logic [7:0] exp_q[$];
    int         err_count = 0;
    int         checked = 0;
    int         n, periph_n, watch_n;
    always #2 mclk = ~mclk;
    system_clock_source_control #(.STAB_TICKS(8)) DUT (
        .mclk(mclk), .srst(srst), .req(req), .rdata(rdata),
        .main_osc_tick(main_osc_tick), .sub_osc_tick(sub_osc_tick),
        .stop_req(stop_req), .halt_req(halt_req), .wake(wake),
        .main_osc_en(main_osc_en), .sub_osc_en(sub_osc_en),
        .feedback_resistor_off(feedback_resistor_off), .cpu_clk_en(cpu_clk_en),
        .cpu_running(cpu_running), .cpu_clk_source_flag(cpu_clk_source_flag),
        .periph_clk_en(periph_clk_en), .watch_clk_en(watch_clk_en),
        .stop_mode(stop_mode), .halt_mode(halt_mode));
    osc_model osc (.mclk(mclk), .main_osc_en(main_osc_en), .sub_osc_en(sub_osc_en),
        .main_osc_tick(main_osc_tick), .sub_osc_tick(sub_osc_tick));
    // ----------------------------------------------------------------
    // checking and bus tasks
    // ----------------------------------------------------------------
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        checked++;
        if (seen !== exp) begin
            err_count++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic ok(input logic c);
        check({7'h0, c}, 8'h01);
    endtask
    task automatic complete_run;
        $display("comparisons %0d mismatches %0d", checked, err_count);
        if (err_count == 0 && checked > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic issue(input reg_req_t r);
        @(posedge mclk);
        req <= r;
        @(posedge mclk);
        req <= '0;
    endtask
    task automatic wr(input logic [15:0] a, input logic [7:0] v);
        issue('{a, 1'b0, 1'b1, v, 1'b0, 3'h0, 1'b0});
    endtask
    task automatic bwr(input logic [15:0] a, input logic [2:0] i, input logic v);
        issue('{a, 1'b0, 1'b0, 8'h00, 1'b1, i, v});
    endtask
    task automatic rd(input logic [15:0] a, input logic [7:0] e);
        exp_q.push_back(e);
        issue('{a, 1'b1, 1'b0, 8'h00, 1'b0, 3'h0, 1'b0});
    endtask
    // cycles between two cpu clock pulses
    task automatic tick_gap(input int e);
        int k;
        k = 0;
        repeat (400) begin
            @(negedge mclk);
            if (cpu_clk_en === 1'b1) break;
        end
        do begin
            @(negedge mclk);
            k++;
        end while (cpu_clk_en !== 1'b1 && k < 400);
        check(8'(k), 8'(e));
    endtask
    always @(posedge mclk) rd_d <= req.rd;
    always @(negedge mclk) begin
        periph_n += int'(periph_clk_en === 1'b1);
        watch_n += int'(watch_clk_en === 1'b1);
        if (rd_d) check(rdata, exp_q.pop_front());
    end
    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial begin
        void'($urandom(32'h9494));
        repeat (12) @(posedge mclk);
        @(negedge mclk);
        ok(main_osc_en === 1'b0);
        @(posedge mclk);
        srst <= 1'b0;
        n = 0;
        while (cpu_running !== 1'b1 && n < 50) begin
            @(negedge mclk);
            n += int'(main_osc_tick === 1'b1);
        end
        ok(n >= 8 && n <= 10);
        rd(16'hfff0, 8'h00);
        rd(16'hfff2, 8'h00);
        rd(16'hfffb, 8'h02);
        rd(16'hfff4, 8'h00);
        tick_gap(8);
        repeat (4) begin
            d = 8'($urandom()) & 8'h03;
            wr(16'hfff0, d);
            @(negedge mclk);
            ok(sub_osc_en === ~d[0] && feedback_resistor_off === d[1]);
            rd(16'hfff0, d);
        end
        wr(16'hfff0, 8'h00);
        bwr(16'hfff0, 3'h1, 1'b1);
        rd(16'hfff0, 8'h02);
        bwr(16'hfff0, 3'h1, 1'b0);
        wr(16'hfffb, 8'h80);
        rd(16'hfffb, 8'h00);
        ok(main_osc_en === 1'b1);
        periph_n = 0;
        repeat (40) @(negedge mclk);
        ok(periph_n == 20);
        tick_gap(2);
        bwr(16'hfff2, 3'h4, 1'b1);
        @(negedge mclk);
        ok(cpu_clk_source_flag === 1'b0);
        n = 0;
        while (cpu_clk_source_flag !== 1'b1 && n++ < 100) @(negedge mclk);
        ok(cpu_clk_source_flag === 1'b1);
        rd(16'hfff2, 8'h30);
        bwr(16'hfff2, 3'h5, 1'b0);
        rd(16'hfff2, 8'h30);
        tick_gap(14);
        wr(16'hfffb, 8'h80);
        repeat (4) @(negedge mclk);
        ok(main_osc_en === 1'b0);
        rd(16'hfffb, 8'h80);
        periph_n = 0;
        watch_n = 0;
        repeat (60) @(negedge mclk);
        ok(periph_n == 0);
        ok(watch_n >= 4);
        @(posedge mclk);
        stop_req <= 1'b1;
        repeat (10) @(negedge mclk);
        ok(stop_mode === 1'b0 && cpu_running === 1'b1);
        @(posedge mclk);
        stop_req <= 1'b0;
        halt_req <= 1'b1;
        repeat (3) @(negedge mclk);
        ok(halt_mode === 1'b1 && cpu_clk_en === 1'b0);
        @(posedge mclk);
        halt_req <= 1'b0;
        wake <= 1'b1;
        repeat (3) @(negedge mclk);
        ok(cpu_running === 1'b1 && halt_mode === 1'b0);
        @(posedge mclk);
        wake <= 1'b0;
        wr(16'hfffb, 8'h00);
        bwr(16'hfff2, 3'h4, 1'b0);
        n = 0;
        while (cpu_clk_source_flag !== 1'b0 && n++ < 100) @(negedge mclk);
        ok(cpu_clk_source_flag === 1'b0);
        @(posedge mclk);
        stop_req <= 1'b1;
        repeat (4) @(negedge mclk);
        ok(stop_mode === 1'b1 && main_osc_en === 1'b0);
        @(posedge mclk);
        stop_req <= 1'b0;
        wake <= 1'b1;
        n = 0;
        while (cpu_running !== 1'b1 && n++ < 300) @(negedge mclk);
        ok(cpu_running === 1'b1);
        complete_run();
    end
    initial begin
        #40000;
        err_count++;
        complete_run();
    end
endmodule
